// ==== core/oar_pkg.sv ====
// Shared constants, types and helpers for the result, fault and control registers
package oar_pkg;

  // Register addresses on the serial interface
  localparam logic [7:0]  ADDR_AMB1_RESULT = 8'h2D;
  localparam logic [7:0]  ADDR_LED2_NET    = 8'h2E;
  localparam logic [7:0]  ADDR_LED1_NET    = 8'h2F;
  localparam logic [7:0]  ADDR_FAULT       = 8'h30;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h31;
  localparam logic [7:0]  ADDR_SLEEP_START = 8'h32;
  localparam logic [7:0]  ADDR_SLEEP_END   = 8'h33;

  // Reset values
  localparam logic [23:0] RESULT_RST       = 24'h00_0000;
  localparam logic [12:0] FAULT_RST        = 13'h0000;
  localparam logic [15:0] SLEEP_CNT_RST    = 16'h0000;
  localparam logic [2:0]  DIV_CODE_RST     = 3'h0;

  // Field positions
  localparam int          THIRD_SEL_BIT    = 15;
  localparam int          SO_HIZ_BIT       = 4;
  localparam int          CO_HIZ_BIT       = 3;
  localparam int          DIV_LSB          = 0;
  localparam int          DIV_MSB          = 2;
  localparam int          FAULT_MSB        = 12;
  localparam int          SLEEP_MSB        = 15;
  localparam int          ADDR_BITS        = 8;
  localparam int          DATA_BITS        = 24;
  localparam int          FRAME_BITS       = 32;

  // Fault flag positions
  localparam int          PHOTODIODE_ALARM_FLAG        = 12;
  localparam int          EMITTER_ALARM_FLAG           = 11;
  localparam int          SECOND_EMITTER_OPEN_FLAG     = 10;
  localparam int          FIRST_EMITTER_OPEN_FLAG      = 9;
  localparam int          EMITTER_SHORT_FLAG           = 8;
  localparam int          NEG_DRIVE_GROUND_SHORT_FLAG  = 7;
  localparam int          POS_DRIVE_GROUND_SHORT_FLAG  = 6;
  localparam int          PHOTODIODE_OPEN_FLAG         = 5;
  localparam int          PHOTODIODE_SHORT_FLAG        = 4;
  localparam int          NEG_INPUT_GROUND_SHORT_FLAG  = 3;
  localparam int          POS_INPUT_GROUND_SHORT_FLAG  = 2;
  localparam int          NEG_INPUT_EMITTER_SHORT_FLAG = 1;
  localparam int          POS_INPUT_EMITTER_SHORT_FLAG = 0;

  // Divider codes and their ratios
  localparam logic [2:0]  DIV_CODE_2       = 3'h0;
  localparam logic [2:0]  DIV_CODE_4       = 3'h2;
  localparam logic [2:0]  DIV_CODE_6       = 3'h3;
  localparam logic [2:0]  DIV_CODE_8       = 3'h4;
  localparam logic [2:0]  DIV_CODE_12      = 3'h5;
  localparam logic [2:0]  DIV_CODE_1       = 3'h7;
  localparam logic [3:0]  DIV_RATIO_1      = 4'h1;
  localparam logic [3:0]  DIV_RATIO_2      = 4'h2;
  localparam logic [3:0]  DIV_RATIO_4      = 4'h4;
  localparam logic [3:0]  DIV_RATIO_6      = 4'h6;
  localparam logic [3:0]  DIV_RATIO_8      = 4'h8;
  localparam logic [3:0]  DIV_RATIO_12     = 4'hC;

  localparam int          FIFO_DEPTH       = 4;

  typedef enum logic [1:0] {
    SMP_LED2 = 2'h0,
    SMP_AMB2 = 2'h1,
    SMP_LED1 = 2'h2,
    SMP_AMB1 = 2'h3
  } oar_smp_kind_t;

  typedef struct packed {
    oar_smp_kind_t kind;
    logic [23:0]   value;
  } oar_sample_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_ADDR = 2'b01,
    SPI_DATA = 2'b11
  } oar_spi_state_t;

  // Forbidden codes fall back to divide-by-2 so the divider never stalls
  function automatic logic [3:0] oar_div_ratio(input logic [2:0] code);
    case (code)
      DIV_CODE_2:  oar_div_ratio = DIV_RATIO_2;
      DIV_CODE_4:  oar_div_ratio = DIV_RATIO_4;
      DIV_CODE_6:  oar_div_ratio = DIV_RATIO_6;
      DIV_CODE_8:  oar_div_ratio = DIV_RATIO_8;
      DIV_CODE_12: oar_div_ratio = DIV_RATIO_12;
      DIV_CODE_1:  oar_div_ratio = DIV_RATIO_1;
      default:     oar_div_ratio = DIV_RATIO_2;
    endcase
  endfunction

endpackage

// ==== core/oar_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
module oar_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign inReady  = !((wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]));
  assign outValid = (wrPtr_r != rdPtr_r);
  assign outData  = mem[rdPtr_r[AW-1:0]];
  assign push     = ce && inValid && inReady;
  assign pop      = ce && outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end

endmodule

// ==== core/oar_result_fault_flags_ctrl.sv ====
// Result, fault-flag and output/divider/sleep-window control registers with serial access
module oar_result_fault_flags_ctrl (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic                spiClk,
  input  wire logic                spiSelect_b,
  input  wire logic                spiDataIn,
  input  wire logic                spiReadEnable,
  output logic                     serialDataOutPin,
  output logic                     serialDataOutOe,
  input  wire oar_pkg::oar_sample_t sampleIn,
  input  wire logic                sampleValid,
  output logic                     sampleAccept,
  output logic                     convReady,
  input  wire logic                faultCheckStart,
  input  wire logic                faultCheckEnd,
  input  wire logic [12:0]         faultVector,
  output logic                     faultCheckDonePin,
  input  wire logic                posEmitterCtl,
  output logic                     posEmitterPin,
  output logic                     thirdEmitterPin,
  output logic                     dividedClockOut,
  output logic                     dividedClockOutOe,
  output logic                     dividedClockTick,
  input  wire logic                periodStart,
  input  wire logic                sleepAdcPartEn,
  input  wire logic                sleepTiaEn,
  input  wire logic                sleepAdcRestEn,
  output logic                     dynamicSleepSignal,
  output logic                     adcPartSleep,
  output logic                     tiaSleep,
  output logic                     adcRestSleep
);
  import oar_pkg::*;

  // Pin synchronisers
  logic                 sclkS1_r, sclkS2_r, sclkS3_r;
  logic                 selS1_r, selS2_r;
  logic                 mosiS1_r, mosiS2_r;
  logic                 sclkRise, sclkFall, frameActive;

  // Serial frame engine
  oar_spi_state_t       spiState_r;
  logic [4:0]           bitCnt_r;
  logic [7:0]           addr_r;
  logic [22:0]          rxShift_r;
  logic [23:0]          txShift_r;
  logic [23:0]          readWord;
  logic [23:0]          wrData;
  logic                 wrStrobe;

  // Results
  oar_sample_t          fifoOut;
  logic                 fifoOutValid, fifoPop;
  logic [23:0]          led2Raw_r, led1Raw_r, amb2Raw_r;
  logic [23:0]          amb1Result_r, led2Net_r, led1Net_r;

  // Faults and control
  logic [12:0]          faultFlags_r;
  logic                 thirdSel_r, soHiz_r, coHiz_r;
  logic [2:0]           divCode_r;
  logic [15:0]          sleepStart_r, sleepEnd_r;

  // Divider and repetition period
  logic [3:0]           divRatio, divCnt_r;
  logic [15:0]          prpCnt_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {sclkS1_r, sclkS2_r, sclkS3_r} <= 3'h0;
      {selS1_r, selS2_r}             <= 2'h3;
      {mosiS1_r, mosiS2_r}           <= 2'h0;
    end else if (ce) begin
      sclkS1_r <= spiClk;
      sclkS2_r <= sclkS1_r;
      sclkS3_r <= sclkS2_r;
      selS1_r  <= spiSelect_b;
      selS2_r  <= selS1_r;
      mosiS1_r <= spiDataIn;
      mosiS2_r <= mosiS1_r;
    end
  end

  // Host serial clock must stay well below clk_sys/4 for the edge detector
  assign sclkRise    = sclkS2_r && !sclkS3_r;
  assign sclkFall    = !sclkS2_r && sclkS3_r;
  assign frameActive = !selS2_r;
  assign wrData      = {rxShift_r, mosiS2_r};
  assign wrStrobe    = ce && frameActive && sclkRise && (spiState_r == SPI_DATA)
                       && (bitCnt_r == 5'(FRAME_BITS - 1)) && !spiReadEnable;

  always_comb begin
    readWord = 24'h00_0000;
    case (addr_r)
      ADDR_AMB1_RESULT: readWord = amb1Result_r;
      ADDR_LED2_NET:    readWord = led2Net_r;
      ADDR_LED1_NET:    readWord = led1Net_r;
      ADDR_FAULT:       readWord = {11'h000, faultFlags_r};
      ADDR_CONTROL: begin
        readWord[THIRD_SEL_BIT]   = thirdSel_r;
        readWord[SO_HIZ_BIT]      = soHiz_r;
        readWord[CO_HIZ_BIT]      = coHiz_r;
        readWord[DIV_MSB:DIV_LSB] = divCode_r;
      end
      ADDR_SLEEP_START: readWord = {8'h00, sleepStart_r};
      ADDR_SLEEP_END:   readWord = {8'h00, sleepEnd_r};
      default:          readWord = 24'h00_0000;
    endcase
  end

  // Frame: 8 address bits then 24 data bits, MSB first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      spiState_r <= SPI_IDLE;
      bitCnt_r   <= 5'h00;
      addr_r     <= 8'h00;
      rxShift_r  <= 23'h00_0000;
    end else if (ce) begin
      if (!frameActive) begin
        spiState_r <= SPI_IDLE;
        bitCnt_r   <= 5'h00;
      end else begin
        case (spiState_r)
          SPI_IDLE: spiState_r <= SPI_ADDR;
          SPI_ADDR: begin
            if (sclkRise && bitCnt_r == 5'(ADDR_BITS - 1)) begin
              spiState_r <= SPI_DATA;
              addr_r     <= {rxShift_r[6:0], mosiS2_r};
            end
          end
          SPI_DATA: begin
            if (sclkRise && bitCnt_r == 5'(FRAME_BITS - 1)) begin
              spiState_r <= SPI_ADDR;
            end
          end
          default: spiState_r <= SPI_IDLE;
        endcase
        if (sclkRise && spiState_r != SPI_IDLE) begin
          rxShift_r <= wrData[22:0];
          bitCnt_r  <= bitCnt_r + 5'h01;
        end
      end
    end
  end

  // Read word is loaded once the address is known, then shifted out on falling edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txShift_r <= 24'h00_0000;
    end else if (ce) begin
      if (spiState_r == SPI_DATA && bitCnt_r == 5'(ADDR_BITS) && !sclkS2_r
          && spiReadEnable && sclkFall) begin
        txShift_r <= txShift_r;
      end
      if (spiState_r == SPI_ADDR && sclkRise && bitCnt_r == 5'(ADDR_BITS - 1)) begin
        txShift_r <= spiReadEnable ? 24'h00_0000 : txShift_r;
      end else if (spiState_r == SPI_DATA && bitCnt_r == 5'(ADDR_BITS) && !sclkS2_r
                   && !sclkFall && spiReadEnable && txShift_r == 24'h00_0000) begin
        txShift_r <= readWord;
      end else if (spiState_r == SPI_DATA && sclkFall && bitCnt_r != 5'(ADDR_BITS)) begin
        txShift_r <= {txShift_r[22:0], 1'b0};
      end
    end
  end

  assign serialDataOutPin = txShift_r[23];
  // Driver floats only on software request; idle float is left to the host
  assign serialDataOutOe  = !soHiz_r;

  // Writes to result and fault addresses are dropped; unused bits are not stored
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      thirdSel_r   <= 1'b0;
      soHiz_r      <= 1'b0;
      coHiz_r      <= 1'b0;
      divCode_r    <= DIV_CODE_RST;
      sleepStart_r <= SLEEP_CNT_RST;
      sleepEnd_r   <= SLEEP_CNT_RST;
    end else if (wrStrobe) begin
      case (addr_r)
        ADDR_CONTROL: begin
          thirdSel_r <= wrData[THIRD_SEL_BIT];
          soHiz_r    <= wrData[SO_HIZ_BIT];
          coHiz_r    <= wrData[CO_HIZ_BIT];
          divCode_r  <= wrData[DIV_MSB:DIV_LSB];
        end
        ADDR_SLEEP_START: sleepStart_r <= wrData[SLEEP_MSB:0];
        ADDR_SLEEP_END:   sleepEnd_r   <= wrData[SLEEP_MSB:0];
        default: ;
      endcase
    end
  end

  // Results are held still while a host frame runs so a read is never torn
  oar_fifo #(
    .WIDTH ($bits(oar_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .ce       (ce),
    .inData   (sampleIn),
    .inValid  (sampleValid),
    .inReady  (sampleAccept),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (!frameActive)
  );

  assign fifoPop = ce && fifoOutValid && !frameActive;

  // Net results stay sample minus ambient, which plots upside down; consumers negate
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      led2Raw_r    <= RESULT_RST;
      led1Raw_r    <= RESULT_RST;
      amb2Raw_r    <= RESULT_RST;
      amb1Result_r <= RESULT_RST;
      led2Net_r    <= RESULT_RST;
      led1Net_r    <= RESULT_RST;
    end else if (fifoPop) begin
      case (fifoOut.kind)
        SMP_LED2: led2Raw_r <= fifoOut.value;
        SMP_AMB2: begin
          amb2Raw_r <= fifoOut.value;
          led2Net_r <= led2Raw_r - fifoOut.value;
        end
        SMP_LED1: led1Raw_r <= fifoOut.value;
        SMP_AMB1: begin
          amb1Result_r <= fifoOut.value;
          led1Net_r    <= led1Raw_r - fifoOut.value;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      convReady <= 1'b0;
    end else if (ce) begin
      convReady <= fifoPop;
    end
  end

  // Flags are snapshots of the sequencer outcome; end of check wins over a restart
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      faultFlags_r      <= FAULT_RST;
      faultCheckDonePin <= 1'b0;
    end else if (ce) begin
      if (faultCheckEnd) begin
        faultFlags_r      <= faultVector;
        faultCheckDonePin <= 1'b1;
      end else if (faultCheckStart) begin
        faultCheckDonePin <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      posEmitterPin   <= 1'b0;
      thirdEmitterPin <= 1'b0;
    end else if (ce) begin
      posEmitterPin   <= thirdSel_r ? 1'b0 : posEmitterCtl;
      thirdEmitterPin <= thirdSel_r ? posEmitterCtl : 1'b0;
    end
  end

  // Divide-by-1 can only show half rate on the pin; the tick still runs every cycle
  assign divRatio = oar_div_ratio(divCode_r);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_r         <= 4'h0;
      dividedClockTick <= 1'b0;
      dividedClockOut  <= 1'b0;
    end else if (ce) begin
      dividedClockTick <= (divCnt_r >= divRatio - 4'h1);
      divCnt_r         <= (divCnt_r >= divRatio - 4'h1) ? 4'h0 : divCnt_r + 4'h1;
      dividedClockOut  <= (divRatio == DIV_RATIO_1) ? !dividedClockOut
                          : (divCnt_r < (divRatio >> 1));
    end
  end

  assign dividedClockOutOe = !coHiz_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prpCnt_r <= 16'h0000;
    end else if (ce) begin
      if (periodStart) begin
        prpCnt_r <= 16'h0000;
      end else if (dividedClockTick && prpCnt_r != 16'hFFFF) begin
        prpCnt_r <= prpCnt_r + 16'h0001;
      end
    end
  end

  // Equal counts, including both left at zero, give no sleep window at all
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dynamicSleepSignal <= 1'b0;
    end else if (ce) begin
      dynamicSleepSignal <= (prpCnt_r >= sleepStart_r) && (prpCnt_r < sleepEnd_r);
    end
  end

  assign adcPartSleep = dynamicSleepSignal && sleepAdcPartEn;
  assign tiaSleep     = dynamicSleepSignal && sleepTiaEn;
  assign adcRestSleep = dynamicSleepSignal && sleepAdcRestEn;

  property p_ready_on_refresh;
    @(posedge clk_sys) disable iff (!rst_b)
    fifoPop |=> convReady ##1 (convReady == $past(fifoPop));
  endproperty
  a_ready_on_refresh: assert property (p_ready_on_refresh)
    else $error("ready pulse does not follow a result refresh");

  property p_led2_net;
    @(posedge clk_sys) disable iff (!rst_b)
    (fifoPop && fifoOut.kind == SMP_AMB2)
      |=> led2Net_r == $past(led2Raw_r) - $past(fifoOut.value);
  endproperty
  a_led2_net: assert property (p_led2_net)
    else $error("second emitter net result wrong");

  property p_led1_net;
    @(posedge clk_sys) disable iff (!rst_b)
    (fifoPop && fifoOut.kind == SMP_AMB1)
      |=> (led1Net_r == $past(led1Raw_r) - $past(fifoOut.value)) && convReady;
  endproperty
  a_led1_net: assert property (p_led1_net)
    else $error("first emitter net result wrong");

  property p_fault_capture;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && faultCheckEnd) |=> (faultFlags_r == $past(faultVector)) && faultCheckDonePin;
  endproperty
  a_fault_capture: assert property (p_fault_capture)
    else $error("fault flags not captured with done pin");

  property p_fault_ro;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrStrobe && addr_r == ADDR_FAULT && !faultCheckEnd) |=> $stable(faultFlags_r);
  endproperty
  a_fault_ro: assert property (p_fault_ro)
    else $error("fault register changed by a write");

  property p_third_route;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && thirdSel_r && posEmitterCtl) |=> thirdEmitterPin && !posEmitterPin;
  endproperty
  a_third_route: assert property (p_third_route)
    else $error("positive drive not moved to third emitter");

  property p_so_hiz;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrStrobe && addr_r == ADDR_CONTROL) |=> serialDataOutOe == !$past(wrData[SO_HIZ_BIT]);
  endproperty
  a_so_hiz: assert property (p_so_hiz)
    else $error("serial output enable does not follow control bit");

  property p_co_hiz;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrStrobe && addr_r == ADDR_CONTROL) |=> dividedClockOutOe == !$past(wrData[CO_HIZ_BIT]);
  endproperty
  a_co_hiz: assert property (p_co_hiz)
    else $error("clock output enable does not follow control bit");

  property p_div4;
    @(posedge clk_sys) disable iff (!rst_b || !ce)
    // Code must hold through the whole period, else a rewrite would look like a fault
    (dividedClockTick && divCode_r == DIV_CODE_4 && $stable(divCode_r))
      ##1 (divCode_r == DIV_CODE_4)[*3]
      |=> dividedClockTick && !$past(dividedClockTick, 1) && !$past(dividedClockTick, 2)
          && !$past(dividedClockTick, 3);
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide-by-4 tick spacing wrong");

  property p_sleep_window;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && prpCnt_r >= sleepStart_r && prpCnt_r < sleepEnd_r) |=> dynamicSleepSignal;
  endproperty
  a_sleep_window: assert property (p_sleep_window)
    else $error("sleep signal missing inside window");

  property p_sleep_end;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && prpCnt_r >= sleepEnd_r) |=> !dynamicSleepSignal;
  endproperty
  a_sleep_end: assert property (p_sleep_end)
    else $error("sleep signal beyond window end");

  property p_sleep_gate;
    @(posedge clk_sys) disable iff (!rst_b)
    (adcPartSleep || tiaSleep || adcRestSleep) |-> dynamicSleepSignal;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("power-down outside sleep window");

  c_fault_done:  cover property (@(posedge clk_sys) disable iff (!rst_b)
                                 faultCheckEnd ##1 faultCheckDonePin);
  c_ctrl_write:  cover property (@(posedge clk_sys) disable iff (!rst_b)
                                 wrStrobe && addr_r == ADDR_CONTROL);
  c_fifo_full:   cover property (@(posedge clk_sys) disable iff (!rst_b)
                                 sampleValid && !sampleAccept);
  c_sleep:       cover property (@(posedge clk_sys) disable iff (!rst_b)
                                 $rose(dynamicSleepSignal));

endmodule

// ==== test/oar_spi_host.sv ====
// Host-side serial master model for the register pins
module oar_spi_host (
  input  wire logic clk_sys,
  input  wire logic serialDataOutPin,
  input  wire logic serialDataOutOe,
  output logic      spiClk,
  output logic      spiSelect_b,
  output logic      spiDataIn,
  output logic      spiReadEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Six system clocks per half period keeps clear of the three-stage synchroniser
  localparam int HALF = 6;

  initial {spiClk, spiSelect_b, spiDataIn, spiReadEnable} = 4'h4;

  // Address then data, MSB first; q keeps the last 24 bits seen on the data-out pin
  task automatic frame(input logic [7:0] a, input logic [23:0] d, input logic rd,
                       output logic [23:0] q);
    logic [31:0] w;
    w = {a, d};
    q = 24'h00_0000;
    @(negedge clk_sys);
    spiReadEnable = rd;
    spiSelect_b = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spiDataIn = w[i];
      repeat (HALF) @(negedge clk_sys);
      spiClk = 1'b1;
      // A floating pin is seen as the inverse of the last bit, not as a lucky match
      q = {q[22:0], serialDataOutOe ? serialDataOutPin : ~q[0]};
      repeat (HALF) @(negedge clk_sys);
      spiClk = 1'b0;
    end
    spiDataIn = ~w[0];
    spiSelect_b = 1'b1;
    repeat (HALF) @(negedge clk_sys);
  endtask
endmodule

// ==== test/optical_afe_result_fault_flags_ctrl_regs_tb_top.sv ====
// Self-checking bench for the result, fault and control registers
module optical_afe_result_fault_flags_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oar_pkg::*;
  logic clk_sys, rst_b, ce, spiClk, spiSelect_b, spiDataIn, spiReadEnable;
  logic serialDataOutPin, serialDataOutOe, sampleValid, sampleAccept, convReady;
  logic faultCheckStart, faultCheckEnd, faultCheckDonePin, posEmitterCtl, posEmitterPin;
  logic thirdEmitterPin, dividedClockOut, dividedClockOutOe, dividedClockTick, periodStart;
  logic sleepAdcPartEn, sleepTiaEn, sleepAdcRestEn, dynamicSleepSignal, adcPartSleep;
  logic tiaSleep, adcRestSleep;
  logic [12:0] faultVector;
  oar_sample_t sampleIn;
  logic [23:0] q, got, w;
  logic [23:0] expQ[$];
  logic [23:0] s[4];
  int          miscompares, total_checks, readyCnt, tickCnt, slpCnt, hiCnt, gateCnt;
  event        gotEv;

  oar_result_fault_flags_ctrl DUT (.*);
  oar_spi_host HOST (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    readyCnt += convReady;
    tickCnt += dividedClockTick;
    hiCnt += dividedClockOut;
    slpCnt += dynamicSleepSignal;
    gateCnt += adcPartSleep + tiaSleep + adcRestSleep;
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    expQ.push_back(e);
    HOST.frame(a, 24'h00_0000, 1'b1, q);
    got = q;
    ->gotEv;
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    HOST.frame(a, d, 1'b0, q);
  endtask

  task automatic push4();
    sampleValid = 1'b1;
    foreach (s[i]) begin
      sampleIn = {2'(i), s[i]};
      @(posedge clk_sys iff sampleAccept);
      @(negedge clk_sys);
    end
    sampleValid = 1'b0;
  endtask

  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial forever begin
    @(gotEv);
    chk(got, expQ.pop_front());
  end

  // Covers the whole planned sequence with a wide margin
  initial begin
    #200_000;
    miscompares++;
    end_sim();
  end

  initial begin
    static logic [2:0] codes[6] = '{DIV_CODE_2, DIV_CODE_4, DIV_CODE_6, DIV_CODE_8,
                                    DIV_CODE_12, DIV_CODE_1};
    static int         ratio[6] = '{2, 4, 6, 8, 12, 1};
    {rst_b, ce, sampleValid, faultCheckStart, faultCheckEnd, periodStart} = 6'h10;
    {posEmitterCtl, sleepAdcPartEn, sleepTiaEn, sleepAdcRestEn} = 4'hF;
    {faultVector, sampleIn} = '0;
    void'($urandom(88));
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    for (logic [7:0] a = ADDR_AMB1_RESULT; a <= ADDR_SLEEP_END; a++) rd(a, 24'h00_0000);
    faultVector = 13'($urandom);
    faultCheckEnd = 1'b1;
    @(negedge clk_sys);
    faultCheckEnd = 1'b0;
    w = {11'h000, faultVector};
    faultVector = ~faultVector;
    @(negedge clk_sys);
    chk(faultCheckDonePin, 24'h00_0001);
    wr(ADDR_FAULT, {11'h000, faultVector});
    rd(ADDR_FAULT, w);
    faultCheckStart = 1'b1;
    @(negedge clk_sys);
    faultCheckStart = 1'b0;
    @(negedge clk_sys);
    chk(faultCheckDonePin, 24'h00_0000);
    // End and restart in one cycle: the end must win
    {faultCheckStart, faultCheckEnd} = 2'h3;
    @(negedge clk_sys);
    {faultCheckStart, faultCheckEnd} = 2'h0;
    @(negedge clk_sys);
    chk(faultCheckDonePin, 24'h00_0001);
    rd(ADDR_FAULT, {11'h000, faultVector});
    foreach (s[i]) s[i] = 24'($urandom);
    readyCnt = 0;
    push4();
    repeat (8) @(negedge clk_sys);
    chk(24'(readyCnt), 24'h00_0004);
    // Samples arriving during a frame wait in the buffer, so the read is never torn
    fork
      rd(ADDR_AMB1_RESULT, s[3]);
      begin
        repeat (10) @(negedge clk_sys);
        push4();
        chk(sampleAccept, 24'h00_0000);
        chk(24'(readyCnt), 24'h00_0004);
      end
    join
    repeat (8) @(negedge clk_sys);
    chk(24'(readyCnt), 24'h00_0008);
    rd(ADDR_LED2_NET, s[0] - s[1]);
    rd(ADDR_LED1_NET, s[2] - s[3]);
    foreach (codes[i]) begin
      w = {8'h00, 1'($urandom), 10'h000, 1'b0, 1'($urandom), codes[i]};
      posEmitterCtl = 1'($urandom);
      wr(ADDR_CONTROL, w);
      rd(ADDR_CONTROL, w);
      chk(dividedClockOutOe, !w[3]);
      chk(serialDataOutOe, 24'h00_0001);
      chk(thirdEmitterPin, posEmitterCtl & w[15]);
      chk(posEmitterPin, posEmitterCtl & !w[15]);
      tickCnt = 0;
      hiCnt = 0;
      repeat (24 * ratio[i]) @(negedge clk_sys);
      chk(24'(tickCnt), 24'h00_0018);
      chk(24'(hiCnt), 24'(12 * ratio[i]));
    end
    wr(ADDR_CONTROL, 24'h00_0010);
    chk(serialDataOutOe, 24'h00_0000);
    wr(ADDR_CONTROL, 24'h00_0000);
    wr(ADDR_SLEEP_START, 24'h00_0002);
    wr(ADDR_SLEEP_END, 24'h00_0005);
    rd(ADDR_SLEEP_START, 24'h00_0002);
    rd(ADDR_SLEEP_END, 24'h00_0005);
    {sleepAdcPartEn, sleepTiaEn, sleepAdcRestEn} = 3'($urandom);
    slpCnt = 0;
    gateCnt = 0;
    periodStart = 1'b1;
    @(negedge clk_sys);
    periodStart = 1'b0;
    repeat (40) @(negedge clk_sys);
    // Window counts 2 to 4 at divide-by-2 gives three ticks of two clocks
    chk(24'(slpCnt), 24'h00_0006);
    chk(24'(gateCnt), 24'(6 * (sleepAdcPartEn + sleepTiaEn + sleepAdcRestEn)));
    end_sim();
  end
endmodule
